/* File: include/pis_pkg.sv */
// Constants, codes and register map of the programmable input and preset select block.
//==============================================================================
// Operation
// - Per-input function select; duplicate functions rejected.
// - Function codes decode to fixed functions.
// - Thermistor code accepted on input five only.
// - Inputs default to normally-open operation.
// - Per-input polarity: 00 open, 01 closed.
// - Fault clear and thermistor always normally-open.
// - Clockwise input active drives clockwise, else coast.
// - Anticlockwise input active drives anticlockwise, else coast.
// - Both run inputs active means coast stop.
// - Start source 01 uses terminals, else keypad.
// - Run input active at power-up starts immediately.
// - Polarity change to closed evaluates immediately.
// - Four select bits index normal setpoint or presets.
// - Unassigned select bits read as zero.
// - Jog over nonzero preset over other sources.
// - Live entry writes ignore parameter protection.
// - Live entry only with source 02, stores indexed.
// - Live entry read shows selected frequency.
// - Eight-bit voltage and current scaling, writable running.
// - Setpoint source: 00 pot, 01 analog, 02 keypad.
package pis_pkg;
  //==============================================================================
  // Sizes.
  localparam int NUM_IN   = 6;
  localparam int FREQ_W   = 16;
  localparam int NUM_PRE  = 16;
  //==============================================================================
  // Register indices on the plain register port.
  localparam logic [4:0] REG_FUNC0    = 5'h00;  // 0x00..0x05 function select per input
  localparam logic [4:0] REG_POL0     = 5'h08;  // 0x08..0x0D polarity select per input
  localparam logic [4:0] REG_SP_SRC   = 5'h10;
  localparam logic [4:0] REG_ST_SRC   = 5'h11;
  localparam logic [4:0] REG_V_SCALE  = 5'h12;
  localparam logic [4:0] REG_I_SCALE  = 5'h13;
  localparam logic [4:0] REG_PROTECT  = 5'h14;
  localparam logic [4:0] REG_LIVE     = 5'h15;
  localparam logic [4:0] REG_STATUS   = 5'h16;
  localparam logic [4:0] REG_KEY_RUN  = 5'h17;
  localparam logic [4:0] REG_NORM_SP  = 5'h18;
  localparam logic [4:0] REG_JOG_SP   = 5'h19;
  localparam logic [4:0] REG_PRESET0  = 5'h00;  // Window base for presets, with addr bit 5.
  //==============================================================================
  // Function codes.
  localparam logic [4:0] FN_CW     = 5'h00;
  localparam logic [4:0] FN_CCW    = 5'h01;
  localparam logic [4:0] FN_SEL0   = 5'h02;
  localparam logic [4:0] FN_SEL3   = 5'h05;
  localparam logic [4:0] FN_JOG    = 5'h06;
  localparam logic [4:0] FN_BRAKE  = 5'h07;
  localparam logic [4:0] FN_SET2   = 5'h08;
  localparam logic [4:0] FN_RAMP2  = 5'h09;
  localparam logic [4:0] FN_COAST  = 5'h0B;
  localparam logic [4:0] FN_OFAULT = 5'h0C;
  localparam logic [4:0] FN_RINH   = 5'h0D;
  localparam logic [4:0] FN_PLOCK  = 5'h0F;
  localparam logic [4:0] FN_ILOOP  = 5'h10;
  localparam logic [4:0] FN_FCLR   = 5'h12;
  localparam logic [4:0] FN_THERM  = 5'h13;
  localparam logic [4:0] FN_RAISE  = 5'h1B;
  localparam logic [4:0] FN_LOWER  = 5'h1C;
  localparam int         THERM_IN  = 4;       // Zero-based index of input five.
  // Function reset values for inputs one to six.
  localparam logic [29:0] FUNC_RST = {5'h09, 5'h12, 5'h03, 5'h02, 5'h01, 5'h00};
  //==============================================================================
  // Setting codes and reset values.
  localparam logic [1:0] POL_OPEN   = 2'h0;
  localparam logic [1:0] POL_CLOSED = 2'h1;
  localparam logic [1:0] SRC_POT    = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_KEYPAD = 2'h2;
  localparam logic [1:0] SP_SRC_RST = 2'h1;
  localparam logic [1:0] ST_SRC_TERM = 2'h1;
  localparam logic [1:0] ST_SRC_RST = 2'h1;
  localparam logic [7:0] SCALE_RST  = 8'h80;   // Plain default; real value depends on inverter.
  //==============================================================================
  // Run direction codes.
  typedef enum logic [1:0] {
    PIS_COAST = 2'b00,
    PIS_CW    = 2'b01,
    PIS_CCW   = 2'b10
  } pis_dir_e;
endpackage : pis_pkg

/* File: logic/pis_in_sync.sv */
// Two-stage synchroniser with polarity correction for one terminal.
`timescale 1ns/1ns
module pis_in_sync
  import pis_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic pin,
  input  wire logic invert,
  output logic      active
);
  logic meta_q;
  logic sync_q;

  //==============================================================================
  // Synchroniser; the first stage feeds only the second.
  // sync before use
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // Polarity is applied after the flops so a change acts at once.
  // immediate polarity effect
  assign active = sync_q ^ invert;
endmodule : pis_in_sync

/* File: logic/pis_top.sv */
// Programmable digital inputs, run decode, preset selection and setpoint priority.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module pis_top
  import pis_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [5:0]        term_in,
  input  wire logic              key_on,
  input  wire logic [FREQ_W-1:0] pot_setpoint,
  input  wire logic [FREQ_W-1:0] volt_setpoint,
  input  wire logic [FREQ_W-1:0] curr_setpoint,
  input  wire logic [5:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [15:0]            rdata,
  output logic [1:0]             run_dir,
  output logic [FREQ_W-1:0]      freq_setpoint,
  output logic [3:0]             preset_index,
  output logic [7:0]             active_scale,
  output logic [11:0]            func_flags,
  output logic                   config_error
);
  //==============================================================================
  // Settings.
  logic [4:0]        func_q [NUM_IN];
  logic [1:0]        pol_q  [NUM_IN];
  logic [1:0]        sp_src_q;
  logic [1:0]        st_src_q;
  logic [7:0]        v_scale_q;
  logic [7:0]        i_scale_q;
  logic              protect_q;
  logic              key_run_q;
  logic [FREQ_W-1:0] norm_sp_q;
  logic [FREQ_W-1:0] jog_sp_q;
  logic [FREQ_W-1:0] preset_q [NUM_PRE];

  logic [NUM_IN-1:0] act;
  logic [NUM_IN-1:0] invert;
  logic [NUM_IN-1:0] func_ok;
  logic [NUM_IN-1:0] func_wr;
  logic [NUM_IN-1:0] pol_wr;

  //==============================================================================
  // Per-input synchronisation, polarity and write decode.
  // Each terminal has its own synchroniser, so two pins that move together
  // may be seen one edge apart; the run decode does not filter that brief skew.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      // fault clear and thermistor forced open
      assign invert[gi] = (pol_q[gi] == POL_CLOSED) &&
                          (func_q[gi] != FN_FCLR) && (func_q[gi] != FN_THERM);
      pis_in_sync u_sync (
        .mclk   (mclk),
        .reset  (reset),
        .pin    (term_in[gi]),
        .invert (invert[gi]),
        .active (act[gi])
      );
      // Codes past the last defined one are refused outright.
      // thermistor only on input five
      assign func_ok[gi] = (wdata[4:0] <= FN_LOWER) &&
                           ((wdata[4:0] != FN_THERM) || (gi == THERM_IN)) &&
                           !dup_in(wdata[4:0], gi);
      // Protection blocks function and polarity writes like the other settings.
      assign func_wr[gi] = wr && !protect_q && (addr == {1'b0, REG_FUNC0 + 5'(gi)});
      assign pol_wr[gi]  = wr && !protect_q && (addr == {1'b0, REG_POL0 + 5'(gi)});

      always_ff @(posedge mclk) begin
        if (reset) begin
          func_q[gi] <= FUNC_RST[gi*5 +: 5];
        end else if (func_wr[gi] && func_ok[gi]) begin
          func_q[gi] <= wdata[4:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (reset) begin
          pol_q[gi] <= POL_OPEN;
        end else if (pol_wr[gi] && (wdata[1:0] <= POL_CLOSED)) begin
          pol_q[gi] <= wdata[1:0];
        end
      end
    end
  endgenerate

  // True when another input already carries the requested code.
  // The input being written is skipped, so rewriting its own code is allowed.
  function automatic logic dup_in(input logic [4:0] code, input int self);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NUM_IN; k++) begin
      if ((k != self) && (func_q[k] == code)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : dup_in

  // Active level of the input carrying a function, zero if unassigned.
  function automatic logic fn_act(input logic [4:0] code);
    logic v;
    v = 1'b0;
    for (int k = 0; k < NUM_IN; k++) begin
      if (func_q[k] == code) begin
        v = v | act[k];
      end
    end
    return v;
  endfunction : fn_act

  //==============================================================================
  // Function decode.
  logic       cw_act;
  logic       ccw_act;
  logic       jog_act;
  logic       iloop_act;
  logic [3:0] sel;

  assign cw_act    = fn_act(FN_CW);
  assign ccw_act   = fn_act(FN_CCW);
  assign jog_act   = fn_act(FN_JOG);
  assign iloop_act = fn_act(FN_ILOOP);

  generate
    for (gi = 0; gi < 4; gi++) begin : g_sel
      assign sel[gi] = fn_act(FN_SEL0 + 5'(gi));
    end
  endgenerate

  // Duplicate assignment can only arise from a bad reset image; it is flagged.
  // Writes already refuse both faults, so this flag is only a safety net.
  logic cfg_err_d;
  always_comb begin
    cfg_err_d = 1'b0;
    for (int a = 0; a < NUM_IN; a++) begin
      for (int b = a + 1; b < NUM_IN; b++) begin
        if (func_q[a] == func_q[b]) begin
          cfg_err_d = 1'b1;
        end
      end
      if ((func_q[a] == FN_THERM) && (a != THERM_IN)) begin
        cfg_err_d = 1'b1;
      end
    end
  end

  //==============================================================================
  // Keypad on key comes from the panel, so it passes two flops like a terminal.
  logic key_act;
  pis_in_sync u_key_sync (
    .mclk   (mclk),
    .reset  (reset),
    .pin    (key_on),
    .invert (1'b0),
    .active (key_act)
  );

  //==============================================================================
  // Run decision. Level sensitive, so an input already active runs at once.
  // The keypad start runs clockwise only; the panel offers no reverse.
  pis_dir_e dir_d;
  always_comb begin
    dir_d = PIS_COAST;
    if (st_src_q == ST_SRC_TERM) begin
      if (cw_act && !ccw_act) begin
        dir_d = PIS_CW;
      end else if (ccw_act && !cw_act) begin
        dir_d = PIS_CCW;
      end
    end else if (key_run_q) begin
      dir_d = PIS_CW;
    end
  end

  //==============================================================================
  // Setpoint selection.
  // The preset table is read by the live index, so a new selection acts next edge.
  logic [FREQ_W-1:0] base_sp;
  logic [FREQ_W-1:0] sp_d;
  always_comb begin
    unique case (sp_src_q)
      SRC_POT:    base_sp = pot_setpoint;
      SRC_ANALOG: base_sp = iloop_act ? curr_setpoint : volt_setpoint;
      default:    base_sp = norm_sp_q;
    endcase
    if (jog_act) begin
      sp_d = jog_sp_q;
    end else if (sel != 4'h0) begin
      sp_d = preset_q[sel];
    end else begin
      sp_d = base_sp;
    end
  end

  //==============================================================================
  // Outputs, all registered.
  // Registering costs one cycle of latency but keeps decode glitches off the pins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_dir       <= PIS_COAST;
      freq_setpoint <= '0;
      preset_index  <= 4'h0;
      active_scale  <= SCALE_RST;
      func_flags    <= 12'h000;
      config_error  <= 1'b0;
    end else begin
      run_dir       <= dir_d;
      freq_setpoint <= sp_d;
      preset_index  <= sel;
      active_scale  <= iloop_act ? i_scale_q : v_scale_q;
      func_flags    <= {fn_act(FN_LOWER), fn_act(FN_RAISE), fn_act(FN_THERM),
                        fn_act(FN_FCLR), iloop_act, fn_act(FN_PLOCK), fn_act(FN_RINH),
                        fn_act(FN_OFAULT), fn_act(FN_COAST), fn_act(FN_RAMP2),
                        fn_act(FN_SET2), fn_act(FN_BRAKE)};
      config_error  <= cfg_err_d;
    end
  end

  //==============================================================================
  // Global settings. Protection blocks writes except live entry, protection and key run.
  logic wr_ok;
  assign wr_ok = wr && !protect_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sp_src_q  <= SP_SRC_RST;
      st_src_q  <= ST_SRC_RST;
      v_scale_q <= SCALE_RST;
      i_scale_q <= SCALE_RST;
      protect_q <= 1'b0;
      key_run_q <= 1'b0;
      norm_sp_q <= '0;
      jog_sp_q  <= '0;
    end else begin
      if (wr && (addr == {1'b0, REG_PROTECT})) begin
        protect_q <= wdata[0];
      end
      if (wr && (addr == {1'b0, REG_KEY_RUN})) begin
        key_run_q <= wdata[0];
      end
      if (wr_ok && (addr == {1'b0, REG_SP_SRC}) && (wdata[1:0] <= SRC_KEYPAD)) begin
        sp_src_q <= wdata[1:0];
      end
      if (wr_ok && (addr == {1'b0, REG_ST_SRC})) begin
        st_src_q <= wdata[1:0];
      end
      if (wr_ok && (addr == {1'b0, REG_V_SCALE})) begin
        v_scale_q <= wdata[7:0];
      end
      if (wr_ok && (addr == {1'b0, REG_I_SCALE})) begin
        i_scale_q <= wdata[7:0];
      end
      if (wr_ok && (addr == {1'b0, REG_NORM_SP})) begin
        norm_sp_q <= wdata;
      end
      if (wr_ok && (addr == {1'b0, REG_JOG_SP})) begin
        jog_sp_q <= wdata;
      end
      // A key press wins over a clearing write in the same cycle.
      if (key_act) begin
        key_run_q <= 1'b1;
      end
    end
  end

  //==============================================================================
  // Preset storage; entry 0 is unused because index 0 is the normal setpoint.
  // Entry 0 never takes a write, so it reads as zero through the window.
  logic live_wr;
  assign live_wr = wr && (addr == {1'b0, REG_LIVE}) && (sp_src_q == SRC_KEYPAD);
  generate
    for (gi = 0; gi < NUM_PRE; gi++) begin : g_pre
      always_ff @(posedge mclk) begin
        if (reset) begin
          preset_q[gi] <= '0;
        end else if (wr_ok && addr[5] && (addr[3:0] == 4'(gi)) && (gi != 0)) begin
          preset_q[gi] <= wdata;
        end else if (live_wr && (sel == 4'(gi)) && (gi != 0)) begin
          preset_q[gi] <= wdata;
        end else if (live_wr && (sel == 4'(gi))) begin
          preset_q[gi] <= preset_q[gi];
        end
      end
    end
  endgenerate

  //==============================================================================
  // Read port, data one cycle after the strobe; unmapped reads zero, but 0x30..0x3F mirror the presets.
  // Reads have no side effects, so software may poll the status word freely.
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    if (addr[5]) begin
      rd_d = preset_q[addr[3:0]];
    end else if (addr[4:3] == 2'b00 && addr[2:0] < 3'h6) begin
      rd_d = {11'h000, func_q[addr[2:0]]};
    end else if (addr[4:3] == 2'b01 && addr[2:0] < 3'h6) begin
      rd_d = {14'h0000, pol_q[addr[2:0]]};
    end else begin
      unique case (addr[4:0])
        REG_SP_SRC:  rd_d = {14'h0000, sp_src_q};
        REG_ST_SRC:  rd_d = {14'h0000, st_src_q};
        REG_V_SCALE: rd_d = {8'h00, v_scale_q};
        REG_I_SCALE: rd_d = {8'h00, i_scale_q};
        REG_PROTECT: rd_d = {15'h0000, protect_q};
        REG_LIVE:    rd_d = freq_setpoint;
        REG_STATUS:  rd_d = {3'h0, config_error, preset_index, run_dir, act};
        REG_KEY_RUN: rd_d = {15'h0000, key_run_q};
        REG_NORM_SP: rd_d = norm_sp_q;
        REG_JOG_SP:  rd_d = jog_sp_q;
        default:     rd_d = 16'h0000;
      endcase
    end
  end

  // Read data is zero outside the answer cycle, so stale values never linger.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? rd_d : 16'h0000;
    end
  end
endmodule : pis_top

/* File: sim/pis_top_props.sv */
// Concurrent checks on the ports of the input and preset select block.
`timescale 1ns/1ns
module pis_top_props
  import pis_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [5:0]        term_in,
  input wire logic              key_on,
  input wire logic [5:0]        addr,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [15:0]       rdata,
  input wire logic [1:0]        run_dir,
  input wire logic [FREQ_W-1:0] freq_setpoint,
  input wire logic [3:0]        preset_index,
  input wire logic [7:0]        active_scale,
  input wire logic [11:0]       func_flags,
  input wire logic              config_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  //====================
  // Cause history.
  logic [5:0] term_q;
  logic       key_q;
  logic [4:0] hist_q;
  // Reset counts as a cause, so the synchroniser fill after release is not flagged.
  always_ff @(posedge mclk) begin
    term_q <= term_in;
    key_q  <= key_on;
    hist_q <= reset ? 5'h1F : {hist_q[3:0], (term_in != term_q) | (key_on != key_q) | wr};
  end
  wire logic cause = |hist_q;
  //====================
  // Assertions.
  // No illegal direction.
  chk_dir_legal: assert property (run_dir != 2'b11)
    else $error("Run direction holds an illegal code.");
  chk_dir_cause: assert property ($changed(run_dir) |-> cause)
    else $error("Run direction moved without input activity.");
  chk_index_cause: assert property ($changed(preset_index) |-> cause)
    else $error("Preset index moved without input activity.");
  chk_flags_cause: assert property ($changed(func_flags) |-> cause)
    else $error("Function flags moved without input activity.");
  chk_scale_cause: assert property ($changed(active_scale) |-> cause)
    else $error("Active scale moved without input activity.");
  chk_cfg_cause: assert property ($changed(config_error) |-> cause)
    else $error("Configuration error moved without a write.");
  // Read data only after a read.
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("Read data not zero outside a read answer.");
  chk_live_readback: assert property ((rd && addr == {1'b0, REG_LIVE}) ##1 $stable(freq_setpoint)
    |-> rdata == freq_setpoint)
    else $error("Live entry read differs from the selected frequency.");
  cover property (run_dir == PIS_CCW);
  cover property (preset_index == 4'hF);
  cover property (rd && addr == {1'b0, REG_LIVE});
endmodule : pis_top_props

bind pis_top pis_top_props u_pis_top_props (.mclk(mclk), .reset(reset), .term_in(term_in),
  .key_on(key_on), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .run_dir(run_dir),
  .freq_setpoint(freq_setpoint), .preset_index(preset_index), .active_scale(active_scale),
  .func_flags(func_flags), .config_error(config_error));

/* File: sim/pis_sw_model.sv */
// Behavioural model of the switches wired to the six terminals.
`timescale 1ns/1ns
module pis_sw_model (
  input  wire logic       mclk,
  input  wire logic [5:0] closed,
  output logic      [5:0] term_in
);
  initial term_in = 6'h00;
  // Closed reads high.
  // A closed contact ties its terminal to the supply terminal; moves land after an edge.
  always @(posedge mclk) begin
    term_in <= closed;
  end
endmodule : pis_sw_model

/* File: sim/pis_top_tb.sv */
// Self-checking bench for the input and preset select block.
`timescale 1ns/1ns
module pis_top_tb
  import pis_pkg::*;
();
  logic              mclk, reset, key_on, wr, rd, config_error;
  logic [5:0]        want, term_in, addr;
  logic [15:0]       wdata, rdata, sp_src, st_src, vsc, isc, prot, key_run, norm, jog;
  logic [15:0]       pot_sp, volt_sp, curr_sp, freq_setpoint, fn[6], pol[6], pre[16];
  logic [1:0]        run_dir;
  logic [3:0]        preset_index;
  logic [7:0]        active_scale;
  logic [11:0]       func_flags;
  int                errors, samples_checked, seed, k;
  localparam logic [39:0] FCODES = {FN_LOWER, FN_RAISE, FN_PLOCK, FN_RINH, FN_OFAULT,
                                    FN_COAST, FN_SET2, FN_BRAKE};
  pis_sw_model u_pis_sw_model (.mclk(mclk), .closed(want), .term_in(term_in));
  pis_top u_pis_top (.mclk(mclk), .reset(reset), .term_in(term_in), .key_on(key_on),
    .pot_setpoint(pot_sp), .volt_setpoint(volt_sp), .curr_setpoint(curr_sp), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_dir(run_dir),
    .freq_setpoint(freq_setpoint), .preset_index(preset_index), .active_scale(active_scale),
    .func_flags(func_flags), .config_error(config_error));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  //====================
  // Reference model.
  // Fault clear and thermistor ignore polarity.
  function automatic logic act(int n);
    return want[n] ^ (pol[n] == 1 && fn[n] != FN_FCLR && fn[n] != FN_THERM);
  endfunction : act
  function automatic logic fact(int code);
    logic a;
    a = 1'b0;
    for (int n = 0; n < NUM_IN; n++) a |= (fn[n] == code) && act(n);
    return a;
  endfunction : fact
  function automatic logic [3:0] eidx();
    return {fact(FN_SEL3), fact(FN_SEL0 + 2), fact(FN_SEL0 + 1), fact(FN_SEL0)};
  endfunction : eidx
  function automatic logic [15:0] efreq();
    if (fact(FN_JOG)) return jog;
    if (eidx() != 0) return pre[eidx()];
    if (sp_src == SRC_POT) return pot_sp;
    if (sp_src == SRC_ANALOG) return fact(FN_ILOOP) ? curr_sp : volt_sp;
    return norm;
  endfunction : efreq
  function automatic logic [1:0] edir();
    if (st_src != ST_SRC_TERM) return key_run[0] ? PIS_CW : PIS_COAST;
    if (fact(FN_CW) == fact(FN_CCW)) return PIS_COAST;
    return fact(FN_CW) ? PIS_CW : PIS_CCW;
  endfunction : edir
  function automatic logic [11:0] eflags();
    return {fact(FN_LOWER), fact(FN_RAISE), fact(FN_THERM), fact(FN_FCLR), fact(FN_ILOOP),
      fact(FN_PLOCK), fact(FN_RINH), fact(FN_OFAULT), fact(FN_COAST), fact(FN_RAMP2),
      fact(FN_SET2), fact(FN_BRAKE)};
  endfunction : eflags
  function automatic logic [15:0] mread(int a);
    logic [5:0] av;
    for (int n = 0; n < NUM_IN; n++) av[n] = act(n);
    if (a < NUM_IN) return fn[a];
    if (a >= REG_POL0 && a < REG_POL0 + NUM_IN) return pol[a - REG_POL0];
    case (a)
      REG_SP_SRC:  return sp_src;
      REG_ST_SRC:  return st_src;
      REG_V_SCALE: return vsc;
      REG_I_SCALE: return isc;
      REG_PROTECT: return prot;
      REG_LIVE:    return efreq();
      REG_STATUS:  return {3'h0, 1'b0, eidx(), edir(), av};
      REG_KEY_RUN: return key_run;
      REG_NORM_SP: return norm;
      REG_JOG_SP:  return jog;
      default:     return (a > 'h20 && a < 'h30) ? pre[a - 'h20] : 16'h0000;
    endcase
  endfunction : mread
  function automatic void mwrite(int a, logic [15:0] d);
    logic ok;
    ok = 1'b1;
    if (prot[0] && a != REG_PROTECT && a != REG_KEY_RUN && a != REG_LIVE) return;
    if (a < NUM_IN) begin
      for (int n = 0; n < NUM_IN; n++) ok &= !(n != a && fn[n] == d);
      if (ok && d <= FN_LOWER && (d != FN_THERM || a == THERM_IN)) fn[a] = d;
    end
    else if (a >= REG_POL0 && a < REG_POL0 + NUM_IN) begin
      if (d <= 1) pol[a - REG_POL0] = d;
    end
    else if (a > 'h20 && a < 'h30) pre[a - 'h20] = d;
    else if (a == REG_SP_SRC && d <= 2) sp_src = d;
    else if (a == REG_ST_SRC) st_src = d & 16'h0003;
    else if (a == REG_V_SCALE) vsc = d & 16'h00FF;
    else if (a == REG_I_SCALE) isc = d & 16'h00FF;
    else if (a == REG_PROTECT) prot = d & 16'h0001;
    else if (a == REG_KEY_RUN) key_run = d & 16'h0001;
    else if (a == REG_NORM_SP) norm = d;
    else if (a == REG_JOG_SP) jog = d;
    else if (a == REG_LIVE && sp_src == SRC_KEYPAD && eidx() != 0) pre[eidx()] = d;
  endfunction : mwrite
  //====================
  // Bus, compare and closing tasks.
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic wr_reg(int a, logic [15:0] d);
    @(posedge mclk);
    addr  <= 6'(a);
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    mwrite(a, d);
  endtask : wr_reg
  task automatic rd_reg(int a);
    logic [15:0] e;
    e = mread(a);
    @(posedge mclk);
    addr <= 6'(a);
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    cmp("rdata", e, rdata);
  endtask : rd_reg
  task automatic rd_all();
    for (int a = 0; a < 'h30; a++) rd_reg(a);
  endtask : rd_all
  // Fresh analog values, then terminals settle through switch, sync and output stages.
  task automatic settle();
    pot_sp  <= 16'($random(seed));
    volt_sp <= 16'($random(seed));
    curr_sp <= 16'($random(seed));
    repeat (6) @(posedge mclk);
    #1;
    cmp("run_dir", 16'(edir()), 16'(run_dir));
    cmp("preset_index", 16'(eidx()), 16'(preset_index));
    cmp("freq_setpoint", efreq(), freq_setpoint);
    cmp("active_scale", fact(FN_ILOOP) ? isc : vsc, 16'(active_scale));
    cmp("func_flags", 16'(eflags()), 16'(func_flags));
    cmp("config_error", 16'h0000, 16'(config_error));
  endtask : settle
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end
    else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    finish_test();
  end
  //====================
  // Main sequence.
  initial begin
    {errors, samples_checked, seed} = {32'd0, 32'd0, 32'd1};
    {reset, key_on, wr, rd, addr, wdata, want} = {1'b1, 3'b000, 6'h00, 16'h0000, 6'h01};
    {pot_sp, volt_sp, curr_sp} = 48'h0;
    for (int n = 0; n < NUM_IN; n++) {fn[n], pol[n]} = {16'(FUNC_RST[n*5 +: 5]), 16'h0000};
    foreach (pre[n]) pre[n] = 16'h0000;
    {sp_src, st_src, prot, key_run, norm, jog} = {16'(SP_SRC_RST), 16'(ST_SRC_RST), 64'h0};
    {vsc, isc} = {16'(SCALE_RST), 16'(SCALE_RST)};
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    settle();
    rd_all();
    for (k = 0; k < 4; k++) begin
      want <= {4'($random(seed)), 2'(k)};
      settle();
    end
    wr_reg(1, FN_CW);
    wr_reg(0, FN_THERM);
    wr_reg(REG_POL0, 16'h0002);
    wr_reg(REG_SP_SRC, 16'h0003);
    rd_all();
    wr_reg(4, 16'h0004);
    wr_reg(5, FN_SEL3);
    wr_reg(REG_NORM_SP, 16'($random(seed)));
    for (k = 1; k < NUM_PRE; k++) wr_reg('h20 + k, 16'($random(seed)));
    for (k = 0; k < NUM_PRE; k++) begin
      want <= 6'(k << 2);
      wr_reg(REG_SP_SRC, 16'(k % 3));
      settle();
    end
    want <= 6'h00;
    wr_reg(REG_POL0, 16'h0001);
    settle();
    wr_reg(REG_POL0, 16'h0000);
    // Live entry stores at the index even while protected.
    wr_reg(REG_SP_SRC, 16'(SRC_KEYPAD));
    wr_reg(REG_PROTECT, 16'h0001);
    want <= 6'h14;
    settle();
    wr_reg(REG_LIVE, 16'($random(seed)));
    wr_reg(REG_V_SCALE, 16'h0011);
    wr_reg(REG_POL0 + 2, 16'h0001);
    settle();
    rd_reg(REG_LIVE);
    want <= 6'h00;
    settle();
    wr_reg(REG_LIVE, 16'h1234);
    settle();
    wr_reg(REG_PROTECT, 16'h0000);
    wr_reg(REG_SP_SRC, 16'(SRC_ANALOG));
    wr_reg(4, FN_ILOOP);
    wr_reg(5, FN_JOG);
    wr_reg(REG_JOG_SP, 16'($random(seed)));
    for (k = 0; k < 16; k++) begin
      want <= 6'((k << 2) | 1);
      wr_reg(k[0] ? REG_V_SCALE : REG_I_SCALE, 16'($random(seed) & 'hFF));
      settle();
    end
    wr_reg(4, FN_THERM);
    wr_reg(5, FN_FCLR);
    wr_reg(REG_POL0 + 4, 16'h0001);
    wr_reg(REG_POL0 + 5, 16'h0001);
    for (k = 0; k < 4; k++) begin
      want <= 6'(k << 4);
      settle();
    end
    for (k = 0; k < 8; k++) begin
      wr_reg(1 + k % 3, 16'(FCODES[k*5 +: 5]));
      want <= 6'($random(seed));
      settle();
    end
    // Keypad start source ignores the terminals.
    wr_reg(REG_ST_SRC, 16'h0000);
    want <= 6'h01;
    key_on <= 1'b1;
    @(posedge mclk);
    key_on <= 1'b0;
    key_run = 16'h0001;
    settle();
    wr_reg(REG_KEY_RUN, 16'h0000);
    settle();
    finish_test();
  end
endmodule : pis_top_tb
